// File: shared/t16oc_pkg.sv
// Purpose: constants, types and mode decoding for the 16-bit timer output compare unit
// Assumes: byte-wide register port, two compare channels (A = index 0, B = index 1)
// Notes: offsets are byte addresses on the 4-bit register port
package t16oc_pkg;

  // ==========================================================================
  // sizes
  localparam int T16OC_NCH = 2;
  localparam int T16OC_CW = 16;
  localparam int T16OC_AW = 4;
  localparam int T16OC_DW = 8;

  // ==========================================================================
  // register offsets
  localparam logic [3:0] T16OC_OFS_WAVE = 4'h0;
  localparam logic [3:0] T16OC_OFS_OUTMODE = 4'h1;
  localparam logic [3:0] T16OC_OFS_FORCE = 4'h2;
  localparam logic [3:0] T16OC_OFS_FLAG = 4'h3;
  localparam logic [3:0] T16OC_OFS_IRQEN = 4'h4;
  localparam logic [3:0] T16OC_OFS_STATE = 4'h5;
  localparam logic [3:0] T16OC_OFS_CMPA_LO = 4'h6;
  localparam logic [3:0] T16OC_OFS_CMPA_HI = 4'h7;
  localparam logic [3:0] T16OC_OFS_CMPB_LO = 4'h8;
  localparam logic [3:0] T16OC_OFS_CMPB_HI = 4'h9;

  // ==========================================================================
  // field positions and reset values
  localparam int T16OC_OUTMODE_W = 2;
  localparam int T16OC_WAVE_W = 4;
  localparam logic [1:0] T16OC_OM_NONE = 2'h0;
  localparam logic [1:0] T16OC_OM_TOGGLE = 2'h1;
  localparam logic [1:0] T16OC_OM_CLEAR = 2'h2;
  localparam logic [1:0] T16OC_OM_SET = 2'h3;
  localparam logic [3:0] T16OC_WAVE_NORMAL = 4'h0;
  localparam logic [3:0] T16OC_WAVE_CTC_A = 4'h4;
  localparam logic [3:0] T16OC_WAVE_CTC_CAP = 4'hC;
  localparam logic [3:0] T16OC_WAVE_RST = 4'h0;
  localparam logic [15:0] T16OC_CMP_RST = 16'h0000;
  localparam logic [7:0] T16OC_RD_UNMAPPED = 8'h00;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic [15:0] value;
    logic at_top;
    logic at_floor;
    logic down;
    logic tick;
    logic wr;
  } t16oc_cnt_s;

  typedef struct packed {
    logic [3:0] wave_mode;
    logic [1:0][1:0] out_mode;
    logic [1:0] flag;
    logic [1:0] irq_en;
    logic [1:0] out_state;
    logic [1:0][15:0] active_val;
    logic [1:0][15:0] buffer_val;
    logic [7:0] high_latch;
    logic block;
    logic [1:0] match_pend;
    logic [7:0] rdata;
  } t16oc_state_s;

  // ==========================================================================
  // mode decoding
  function automatic logic t16oc_is_pwm(input logic [3:0] mode);
    return !(mode == T16OC_WAVE_NORMAL || mode == T16OC_WAVE_CTC_A ||
             mode == T16OC_WAVE_CTC_CAP || mode == 4'hD);
  endfunction

  function automatic logic t16oc_is_fast(input logic [3:0] mode);
    return mode == 4'h5 || mode == 4'h6 || mode == 4'h7 || mode == 4'hE || mode == 4'hF;
  endfunction

  // single-slope and frequency-correct modes reload at the floor, the rest at the ceiling
  function automatic logic t16oc_upd_floor(input logic [3:0] mode);
    return t16oc_is_fast(mode) || mode == 4'h8 || mode == 4'h9;
  endfunction

endpackage

// File: rtl/t16oc_out_action.sv
// Purpose: next value of one channel's output state bit
// Assumes: fire and force are one-cycle events already qualified by the caller
// Notes: purely combinational, instantiated once per channel
`timescale 1ns/10ps
module t16oc_out_action import t16oc_pkg::*; (
  input wire logic [3:0] wave_mode_i,
  input wire logic [1:0] out_mode_i,
  input wire logic state_i,
  input wire logic fire_i,
  input wire logic force_i,
  input wire logic tick_i,
  input wire logic at_top_i,
  input wire logic down_i,
  output logic state_nxt_o
);

  logic pwm;
  logic fast;

  assign pwm = t16oc_is_pwm(wave_mode_i);
  assign fast = t16oc_is_fast(wave_mode_i);

  always_comb begin
    state_nxt_o = state_i;
    if (out_mode_i != T16OC_OM_NONE) begin
      if (!pwm) begin
        if (fire_i || force_i) begin
          case (out_mode_i)
            T16OC_OM_TOGGLE: state_nxt_o = ~state_i;
            T16OC_OM_CLEAR: state_nxt_o = 1'b0;
            T16OC_OM_SET: state_nxt_o = 1'b1;
            default: state_nxt_o = state_i;
          endcase
        end
      end else if (out_mode_i != T16OC_OM_TOGGLE) begin
        // toggle has no meaning for a single pwm channel here and is left inert
        if (fast) begin
          if (fire_i) begin
            state_nxt_o = (out_mode_i == T16OC_OM_CLEAR);
          end else if (tick_i && at_top_i) begin
            state_nxt_o = (out_mode_i == T16OC_OM_SET);
          end
        end else if (fire_i) begin
          state_nxt_o = (out_mode_i == T16OC_OM_CLEAR) ? down_i : ~down_i;
        end
      end
    end
  end

endmodule

// File: rtl/t16oc_top.sv
// Purpose: two output compare channels of a 16-bit timer/counter
// Assumes: counter value, ceiling, floor, direction, tick and counter write come from the counter unit
// Notes: byte register port, read data one cycle after the read strobe
//
// Notes on behaviour
// - compare full counter with compare value
// - flag sets one timer tick after match
// - enabled flag requests irq, ack clears
// - writing one clears flag, zero ignored
// - match, ceiling, floor go to waveform logic
// - channel A value serves as ceiling
// - double buffered only in pwm modes
// - buffer reloads at ceiling or floor
// - cpu reaches buffer or active register
// - only writes change value; high read direct
// - high byte latched; low write stores both
// - force acts like match outside pwm modes, no flag
// - counter write blocks next tick matches
// - output state survives waveform mode change
// - output mode bits take effect immediately
// - output mode sets action and pin source
// - reset clears output state bit
// - nonzero mode overrides port value, not direction
// - zero output mode leaves state untouched
`timescale 1ns/10ps
module t16oc_top import t16oc_pkg::*; #(
  parameter int CH_COUNT = T16OC_NCH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire t16oc_cnt_s cnt_i,
  input wire logic [1:0] irq_ack_i,
  output logic [1:0] irq_req_o,
  output logic [1:0] match_o,
  output logic cnt_top_o,
  output logic cnt_floor_o,
  output logic [15:0] ceiling_a_o,
  output logic [1:0] out_state_o,
  input wire logic [1:0] port_value_i,
  input wire logic [1:0] port_dir_i,
  output logic [1:0] pin_out_o,
  output logic [1:0] pin_oe_o
);

  // ==========================================================================
  // elaboration check
  if (CH_COUNT != T16OC_NCH) begin : g_bad_count
    $error("t16oc_top serves exactly two compare channels");
  end

  // ==========================================================================
  // state
  t16oc_state_s st_r;
  t16oc_state_s st_nxt;

  logic dbuf;
  logic [1:0] equal;
  logic [1:0] fire;
  logic [1:0] force_hit;
  logic [1:0] state_next;
  logic [1:0] flag_clear;
  logic wr_wave;
  logic wr_outmode;
  logic wr_force;
  logic wr_flag;
  logic wr_irqen;
  logic [1:0] wr_lo;
  logic [1:0] wr_hi;
  logic [1:0] rd_hi;
  logic [1:0] rd_lo;

  // ==========================================================================
  // decode helpers
  function automatic logic [1:0] cmp_lo_hit(input logic [3:0] addr);
    return {addr == T16OC_OFS_CMPB_LO, addr == T16OC_OFS_CMPA_LO};
  endfunction

  function automatic logic [1:0] cmp_hi_hit(input logic [3:0] addr);
    return {addr == T16OC_OFS_CMPB_HI, addr == T16OC_OFS_CMPA_HI};
  endfunction

  assign dbuf = t16oc_is_pwm(st_r.wave_mode);

  assign wr_wave = reg_wr_i && reg_addr_i == T16OC_OFS_WAVE;
  assign wr_outmode = reg_wr_i && reg_addr_i == T16OC_OFS_OUTMODE;
  assign wr_force = reg_wr_i && reg_addr_i == T16OC_OFS_FORCE;
  assign wr_flag = reg_wr_i && reg_addr_i == T16OC_OFS_FLAG;
  assign wr_irqen = reg_wr_i && reg_addr_i == T16OC_OFS_IRQEN;
  assign wr_lo = reg_wr_i ? cmp_lo_hit(reg_addr_i) : 2'h0;
  assign wr_hi = reg_wr_i ? cmp_hi_hit(reg_addr_i) : 2'h0;
  assign rd_lo = cmp_lo_hit(reg_addr_i);
  assign rd_hi = cmp_hi_hit(reg_addr_i);

  // ==========================================================================
  // per-channel compare and output action
  for (genvar c = 0; c < T16OC_NCH; c++) begin : g_ch
    // the comparator always watches the active register, never the buffer
    assign equal[c] = cnt_i.value == st_r.active_val[c];
    // a pending match lands on the following tick, unless a counter write blocks it
    assign fire[c] = cnt_i.tick && st_r.match_pend[c];
    // force only acts outside the pwm modes
    assign force_hit[c] = wr_force && reg_wdata_i[c] && !dbuf;
    // write-one-to-clear or interrupt service, both drop the flag
    assign flag_clear[c] = (wr_flag && reg_wdata_i[c]) || irq_ack_i[c];

    t16oc_out_action u_action (
      .wave_mode_i(st_r.wave_mode),
      .out_mode_i(st_r.out_mode[c]),
      .state_i(st_r.out_state[c]),
      .fire_i(fire[c]),
      .force_i(force_hit[c]),
      .tick_i(cnt_i.tick),
      .at_top_i(cnt_i.at_top),
      .down_i(cnt_i.down),
      .state_nxt_o(state_next[c])
    );
  end

  // ==========================================================================
  // next state
  always_comb begin
    st_nxt = st_r;

    // configuration writes
    if (wr_wave) begin
      // the output state bits are not touched by a mode change
      st_nxt.wave_mode = reg_wdata_i[T16OC_WAVE_W-1:0];
    end
    if (wr_outmode) begin
      // no shadow copy: the new action applies at the very next event
      st_nxt.out_mode[0] = reg_wdata_i[1:0];
      st_nxt.out_mode[1] = reg_wdata_i[3:2];
    end
    if (wr_irqen) begin
      st_nxt.irq_en = reg_wdata_i[1:0];
    end

    // match blocking: a counter write arms the block, the next tick consumes it
    if (cnt_i.wr) begin
      st_nxt.block = 1'b1;
    end else if (cnt_i.tick) begin
      st_nxt.block = 1'b0;
    end

    // match detection, sampled once per timer tick
    for (int c = 0; c < T16OC_NCH; c++) begin
      if (cnt_i.tick) begin
        st_nxt.match_pend[c] = equal[c] && !st_r.block && !cnt_i.wr;
      end else if (cnt_i.wr) begin
        st_nxt.match_pend[c] = 1'b0;
      end
      // a new match outranks a clear issued in the same cycle
      st_nxt.flag[c] = (st_r.flag[c] && !flag_clear[c]) || fire[c];
      st_nxt.out_state[c] = state_next[c];
    end

    // double-buffer reload at the mode's turning point
    if (dbuf && cnt_i.tick) begin
      if (t16oc_upd_floor(st_r.wave_mode) ? cnt_i.at_floor : cnt_i.at_top) begin
        st_nxt.active_val = st_r.buffer_val;
      end
    end

    // 16-bit compare value writes through the shared high-byte latch
    if (wr_hi != 2'h0) begin
      st_nxt.high_latch = reg_wdata_i;
    end
    for (int c = 0; c < T16OC_NCH; c++) begin
      if (wr_lo[c]) begin
        // both bytes land in one clock so the comparator never sees a torn value
        if (dbuf) begin
          st_nxt.buffer_val[c] = {st_r.high_latch, reg_wdata_i};
        end else begin
          st_nxt.active_val[c] = {st_r.high_latch, reg_wdata_i};
        end
      end
    end

    // read data, valid in the cycle after the strobe only
    st_nxt.rdata = T16OC_RD_UNMAPPED;
    if (reg_rd_i) begin
      case (reg_addr_i)
        T16OC_OFS_WAVE: st_nxt.rdata = {4'h0, st_r.wave_mode};
        T16OC_OFS_OUTMODE: st_nxt.rdata = {4'h0, st_r.out_mode[1], st_r.out_mode[0]};
        T16OC_OFS_FLAG: st_nxt.rdata = {6'h00, st_r.flag};
        T16OC_OFS_IRQEN: st_nxt.rdata = {6'h00, st_r.irq_en};
        T16OC_OFS_STATE: st_nxt.rdata = {6'h00, st_r.out_state};
        default: begin
          for (int c = 0; c < T16OC_NCH; c++) begin
            // high byte comes straight from the target, the latch is write-only
            if (rd_hi[c]) begin
              st_nxt.rdata = dbuf ? st_r.buffer_val[c][15:8] : st_r.active_val[c][15:8];
            end
            if (rd_lo[c]) begin
              st_nxt.rdata = dbuf ? st_r.buffer_val[c][7:0] : st_r.active_val[c][7:0];
            end
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r.wave_mode <= T16OC_WAVE_RST;
      st_r.out_mode <= '0;
      st_r.flag <= 2'h0;
      st_r.irq_en <= 2'h0;
      st_r.out_state <= 2'h0;
      st_r.active_val <= {T16OC_CMP_RST, T16OC_CMP_RST};
      st_r.buffer_val <= {T16OC_CMP_RST, T16OC_CMP_RST};
      st_r.high_latch <= 8'h00;
      st_r.block <= 1'b0;
      st_r.match_pend <= 2'h0;
      st_r.rdata <= T16OC_RD_UNMAPPED;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // outputs
  assign reg_rdata_o = st_r.rdata;
  assign irq_req_o = st_r.flag & st_r.irq_en;
  // match is registered, ceiling and floor pass straight through to the waveform logic
  assign match_o = st_r.match_pend;
  assign cnt_top_o = cnt_i.at_top;
  assign cnt_floor_o = cnt_i.at_floor;
  assign ceiling_a_o = st_r.active_val[0];
  assign out_state_o = st_r.out_state;

  // pin source follows the output mode, direction stays with the port
  for (genvar c = 0; c < T16OC_NCH; c++) begin : g_pin
    assign pin_out_o[c] = (st_r.out_mode[c] != T16OC_OM_NONE) ? st_r.out_state[c] : port_value_i[c];
    assign pin_oe_o[c] = port_dir_i[c];
  end

endmodule

// File: verification/t16oc_cnt_model.sv
// Purpose: stand-in for the counter unit that feeds the compare unit
// Assumes: one tick per cycle while running, counts up and wraps at top_i
// Notes: load_i acts as the cpu store to the counter and is one cycle long
`timescale 1ns/10ps
module t16oc_cnt_model import t16oc_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic load_i,
  input wire logic [15:0] load_val_i,
  input wire logic [15:0] top_i,
  output t16oc_cnt_s cnt_o
);
  // ==========================================
  // counter
  logic [15:0] val_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      val_r <= 16'h0000;
    end else if (load_i) begin
      // the bench never loads the ceiling, and never counts down
      val_r <= load_val_i;
    end else if (run_i) begin
      val_r <= (val_r == top_i) ? 16'h0000 : val_r + 16'h0001;
    end
  end
  assign cnt_o = '{value: val_r, at_top: val_r == top_i, at_floor: val_r == 16'h0000,
    down: 1'b0, tick: run_i, wr: load_i};
endmodule

// File: verification/t16oc_top_properties.sv
// Purpose: port-level checks of the timer output compare unit
// Assumes: channel A is the one watched for stores, pin and state
// Notes: mirrors wave mode, output mode A and the high-byte latch from bus writes
`timescale 1ns/10ps
module t16oc_top_properties import t16oc_pkg::*; #(
  parameter int CH_COUNT = T16OC_NCH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire t16oc_cnt_s cnt_i,
  input wire logic [1:0] irq_ack_i,
  input wire logic [1:0] irq_req_o,
  input wire logic [1:0] match_o,
  input wire logic cnt_top_o,
  input wire logic cnt_floor_o,
  input wire logic [15:0] ceiling_a_o,
  input wire logic [1:0] out_state_o,
  input wire logic [1:0] port_value_i,
  input wire logic [1:0] port_dir_i,
  input wire logic [1:0] pin_out_o,
  input wire logic [1:0] pin_oe_o
);
  // ==========================================
  // register mirrors
  logic [3:0] mode_r;
  logic [1:0] om_r;
  logic [7:0] latch_r;
  logic nonpwm;
  assign nonpwm = mode_r inside {4'h0, 4'h4, 4'hC, 4'hD};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= 4'h0;
      om_r <= 2'h0;
      latch_r <= 8'h00;
    end else if (reg_wr_i) begin
      if (reg_addr_i == T16OC_OFS_WAVE) mode_r <= reg_wdata_i[3:0];
      if (reg_addr_i == T16OC_OFS_OUTMODE) om_r <= reg_wdata_i[1:0];
      // one latch is shared by both channels
      if (reg_addr_i inside {T16OC_OFS_CMPA_HI, T16OC_OFS_CMPB_HI}) latch_r <= reg_wdata_i;
    end
  end
  // ==========================================
  // properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_lo_a; reg_wr_i && reg_addr_i == T16OC_OFS_CMPA_LO && nonpwm; endsequence
  sequence s_wr_then_tick; cnt_i.wr ##1 cnt_i.tick; endsequence
  property p_lo_store; s_lo_a |=> ceiling_a_o == {latch_r, $past(reg_wdata_i)}; endproperty
  a_lo_store: assert property (p_lo_store) else $error("low write did not store both bytes");
  property p_hi_only; reg_wr_i && reg_addr_i == T16OC_OFS_CMPA_HI && !cnt_i.tick |=> $stable(ceiling_a_o); endproperty
  a_hi_only: assert property (p_hi_only) else $error("high write changed compare value");
  property p_rd_idle; !reg_rd_i |=> reg_rdata_o == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
  property p_match_cause;
    $rose(match_o[0]) |-> $past(cnt_i.tick && !cnt_i.wr && cnt_i.value == ceiling_a_o);
  endproperty
  a_match_cause: assert property (p_match_cause) else $error("match without equal count");
  property p_blk; s_wr_then_tick |=> match_o == 2'b00; endproperty
  a_blk: assert property (p_blk) else $error("match after counter write");
  property p_flag_rise;
    $rose(irq_req_o[0]) |-> $past(cnt_i.tick && match_o[0]) || $past(reg_wr_i && reg_addr_i == T16OC_OFS_IRQEN);
  endproperty
  a_flag_rise: assert property (p_flag_rise) else $error("flag set without pending match");
  property p_ack; irq_ack_i[0] && !(cnt_i.tick && match_o[0]) |=> !irq_req_o[0]; endproperty
  a_ack: assert property (p_ack) else $error("service did not clear flag");
  property p_w1c;
    reg_wr_i && reg_addr_i == T16OC_OFS_FLAG && reg_wdata_i[0] && !(cnt_i.tick && match_o[0]) |=> !irq_req_o[0];
  endproperty
  a_w1c: assert property (p_w1c) else $error("writing one did not clear flag");
  property p_pin; pin_out_o[0] == ((om_r != 2'h0) ? out_state_o[0] : port_value_i[0]) && pin_oe_o == port_dir_i;
  endproperty
  a_pin: assert property (p_pin) else $error("pin source wrong");
  property p_om0; om_r == 2'h0 |=> $stable(out_state_o[0]); endproperty
  a_om0: assert property (p_om0) else $error("state moved with output mode zero");
  property p_mode_keep; reg_wr_i && reg_addr_i == T16OC_OFS_WAVE && !cnt_i.tick |=> $stable(out_state_o); endproperty
  a_mode_keep: assert property (p_mode_keep) else $error("state moved on mode change");
  property p_rst_state; $fell(rst_i) |-> out_state_o == 2'b00; endproperty
  a_rst_state: assert property (p_rst_state) else $error("state not cleared by reset");
  property p_ext; cnt_top_o == cnt_i.at_top && cnt_floor_o == cnt_i.at_floor; endproperty
  a_ext: assert property (p_ext) else $error("ceiling or floor not passed on");
endmodule
bind t16oc_top t16oc_top_properties #(.CH_COUNT(CH_COUNT)) i_props (.clk_i, .rst_i, .reg_addr_i, .reg_wdata_i,
  .reg_wr_i, .reg_rd_i, .reg_rdata_o, .cnt_i, .irq_ack_i, .irq_req_o, .match_o, .cnt_top_o, .cnt_floor_o,
  .ceiling_a_o, .out_state_o,
  .port_value_i, .port_dir_i, .pin_out_o, .pin_oe_o);

// File: verification/testbench.sv
// Purpose: directed bus-level test of the timer output compare unit
// Assumes: counter model ticks every cycle while running and wraps at 0x3F
// Notes: port value and direction change once so the pin shows which source drives it
`timescale 1ns/10ps
module testbench import t16oc_pkg::*;;
  logic clk_i = 1'b0, rst_i = 1'b1, wr = 1'b0, rd = 1'b0, run = 1'b0, load = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata;
  logic [1:0] ack = 2'b00, irq, match, ost, pout, poe;
  logic [15:0] ceil, exp_c;
  logic top_f, floor_f;
  t16oc_cnt_s cnt;
  int mismatches = 0, n_tests = 0;
  logic [1:0] pval = 2'b11, pdir = 2'b01;
  t16oc_cnt_model i_cnt (.clk_i, .rst_i, .run_i(run), .load_i(load), .load_val_i(16'h0020),
    .top_i(16'h003F), .cnt_o(cnt));
  t16oc_top i_dut (.clk_i, .rst_i, .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .cnt_i(cnt), .irq_ack_i(ack), .irq_req_o(irq), .match_o(match), .cnt_top_o(top_f),
    .cnt_floor_o(floor_f), .ceiling_a_o(ceil), .out_state_o(ost), .port_value_i(pval), .port_dir_i(pdir),
    .pin_out_o(pout), .pin_oe_o(poe));
  initial forever #4 clk_i = ~clk_i;
  // ==========================================
  // tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  // one strobe cycle; returns just after the answer lands
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk_i);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
  endtask
  task automatic wait_for(input int sel);
    for (int i = 0; i < 200; i++) begin
      if (sel == 0 ? irq[0] === 1'b1 : sel == 1 ? match[0] === 1'b1 : ceil === 16'h0030) break;
      @(posedge clk_i);
      #1;
    end
  endtask
  task automatic test_done();
    if (mismatches == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #(8 * 4000);
    mismatches++;
    test_done();
  end
  // ==========================================
  // scenarios
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int m = 0; m < 12; m++) begin
      bus(1'b0, 4'(m), 8'h00);
      chk(16'(rdata), 16'h0000);
    end
    bus(1'b1, T16OC_OFS_CMPA_HI, 8'h12);
    chk(ceil, 16'h0000);
    bus(1'b1, T16OC_OFS_CMPA_LO, 8'h34);
    chk(ceil, 16'h1234);
    // the shared latch now differs from the stored high byte of channel A
    bus(1'b1, T16OC_OFS_CMPB_HI, 8'h56);
    bus(1'b0, T16OC_OFS_CMPA_HI, 8'h00);
    chk(16'(rdata), 16'h0012);
    exp_c = 16'h1234;
    // pwm modes park the low write in the buffer, the counter is stopped so nothing reloads
    for (int m = 15; m >= 0; m--) begin
      bus(1'b1, T16OC_OFS_WAVE, 8'(m));
      bus(1'b1, T16OC_OFS_CMPA_LO, 8'(m));
      if (m inside {0, 4, 12, 13}) exp_c = {8'h56, 8'(m)};
      chk(ceil, exp_c);
      bus(1'b0, T16OC_OFS_CMPA_LO, 8'h00);
      chk(16'(rdata), 16'(m));
    end
    bus(1'b1, T16OC_OFS_CMPB_LO, 8'hCD);
    bus(1'b0, T16OC_OFS_CMPB_HI, 8'h00);
    chk(16'(rdata), 16'h0056);
    bus(1'b0, T16OC_OFS_CMPB_LO, 8'h00);
    chk(16'(rdata), 16'h00CD);
    bus(1'b1, T16OC_OFS_CMPA_HI, 8'h00);
    bus(1'b1, T16OC_OFS_CMPA_LO, 8'h20);
    bus(1'b1, T16OC_OFS_OUTMODE, 8'h01);
    bus(1'b1, T16OC_OFS_IRQEN, 8'h01);
    run <= 1'b1;
    wait_for(1);
    chk(cnt.value, 16'h0021);
    chk(16'({match[0], irq[0]}), 16'h0002);
    @(posedge clk_i);
    #1 chk(16'({irq[0], ost}), 16'h0005);
    chk(16'({top_f, floor_f}), 16'({cnt.at_top, cnt.at_floor}));
    @(posedge clk_i);
    ack <= 2'b01;
    @(posedge clk_i);
    ack <= 2'b00;
    #1 chk(16'(irq), 16'h0000);
    wait_for(0);
    chk(16'(ost), 16'h0000);
    bus(1'b1, T16OC_OFS_FLAG, 8'h00);
    chk(16'(irq), 16'h0001);
    bus(1'b1, T16OC_OFS_FLAG, 8'h01);
    chk(16'(irq), 16'h0000);
    bus(1'b1, T16OC_OFS_OUTMODE, 8'h00);
    chk(16'({pout, poe}), 16'h000D);
    @(posedge clk_i);
    pval <= 2'b10;
    pdir <= 2'b11;
    #1 chk(16'({pout, poe}), 16'h000B);
    wait_for(0);
    chk(16'(ost), 16'h0000);
    bus(1'b1, T16OC_OFS_FLAG, 8'h01);
    bus(1'b1, T16OC_OFS_OUTMODE, 8'h03);
    chk(16'(pout), 16'h0002);
    run <= 1'b0;
    bus(1'b1, T16OC_OFS_FORCE, 8'h01);
    chk(16'({irq, ost}), 16'h0001);
    bus(1'b1, T16OC_OFS_WAVE, 8'h05);
    chk(16'(ost), 16'h0001);
    bus(1'b1, T16OC_OFS_OUTMODE, 8'h02);
    bus(1'b1, T16OC_OFS_FORCE, 8'h01);
    chk(16'(ost), 16'h0001);
    bus(1'b1, T16OC_OFS_WAVE, 8'h00);
    bus(1'b1, T16OC_OFS_FORCE, 8'h01);
    chk(16'(ost), 16'h0000);
    @(posedge clk_i);
    load <= 1'b1;
    @(posedge clk_i);
    load <= 1'b0;
    run <= 1'b1;
    repeat (4) @(posedge clk_i);
    #1 chk(16'({match, irq}), 16'h0000);
    bus(1'b1, T16OC_OFS_WAVE, 8'h05);
    bus(1'b1, T16OC_OFS_CMPA_HI, 8'h00);
    bus(1'b1, T16OC_OFS_CMPA_LO, 8'h30);
    chk(ceil, 16'h0020);
    wait_for(2);
    chk(cnt.value, 16'h0001);
    test_done();
  end
endmodule
